// ---- src/iatf_pkg.sv ----
// Package: constants and carrier types for the arbitration, timeout and filter block
package iatf_pkg;

  // ----------------------------------------
  // Filter and timeout sizing
  // ----------------------------------------
  localparam int unsigned FILT_MAX_STAGES = 4;
  localparam int unsigned FILT_SEL_W      = 2;
  localparam int unsigned TOUT_W          = 16;
  localparam logic [TOUT_W-1:0] TOUT_LIMIT_RST = 16'hffff;

  // ----------------------------------------
  // Master-side states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    IATF_IDLE  = 2'b00,
    IATF_START = 2'b01,
    IATF_XFER  = 2'b10,
    IATF_LOST  = 2'b11
  } iatf_state_t;

  // Line levels driven by the protocol engine (1 = released)
  typedef struct packed
  {
    logic scl;
    logic sda;
  } iatf_lines_t;

  // Phase qualifiers from the protocol engine
  typedef struct packed
  {
    logic master_tx;
    logic nack_tx;
    logic slave_tx;
  } iatf_phase_t;

  // Event flags reported out
  typedef struct packed
  {
    logic arbitration_lost_detect;
    logic timeout;
    logic start_det;
    logic stop_det;
    logic nack_det;
  } iatf_events_t;

endpackage

// ---- src/iatf_filter.sv ----
// Module: digital noise filter for one bus line
`timescale 1ns/1ps
`default_nettype none

module iatf_filter #(
  parameter int unsigned STAGES = iatf_pkg::FILT_MAX_STAGES
)(
  input  wire logic                            i_core_clk,
  input  wire logic                            i_sys_rst,
  input  wire logic [iatf_pkg::FILT_SEL_W-1:0] i_width,
  input  wire logic                            i_raw,
  output logic                                 o_clean
);

  logic [1:0]        sync;
  logic [STAGES-1:0] shreg;
  logic [STAGES-1:0] next_shreg;
  logic              next_clean;
  logic              all_hi;
  logic              all_lo;

  // ----------------------------------------
  // Sample history and majority-free agreement
  // ----------------------------------------
  always_comb
  begin
    next_shreg = {shreg[STAGES-2:0], sync[1]};
    all_hi     = 1'b1;
    all_lo     = 1'b1;
    for (int i = 0; i < STAGES; i++)
    begin
      if (i <= int'(i_width))
      begin
        all_hi = all_hi & shreg[i];
        all_lo = all_lo & ~shreg[i];
      end
    end
    next_clean = o_clean;
    if (all_hi)
      next_clean = 1'b1;
    else if (all_lo)
      next_clean = 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      sync    <= 2'b11;
      shreg   <= '1;
      o_clean <= 1'b1;
    end
    else
    begin
      sync    <= {sync[0], i_raw};
      shreg   <= next_shreg;
      o_clean <= next_clean;
    end
  end

endmodule

`default_nettype wire

// ---- src/iatf_top.sv ----
// Module: arbitration, SCL timeout and noise filtering for a multi-master two-wire bus
`timescale 1ns/1ps
`default_nettype none

module iatf_top #(
  parameter int unsigned TOUT_W = iatf_pkg::TOUT_W
)(
  input  wire logic                            i_core_clk,
  input  wire logic                            i_sys_rst,
  input  wire logic                            i_scl_in,
  input  wire logic                            i_sda_in,
  output logic                                 o_scl_out,
  output logic                                 o_scl_oe,
  output logic                                 o_sda_out,
  output logic                                 o_sda_oe,
  input  wire logic [iatf_pkg::FILT_SEL_W-1:0] i_filt_width,
  input  wire logic                            i_tout_en,
  input  wire logic [TOUT_W-1:0]               i_tout_limit,
  input  wire logic                            i_start_req,
  input  wire logic                            i_stop_done,
  input  wire iatf_pkg::iatf_lines_t           i_drive,
  input  wire iatf_pkg::iatf_phase_t           i_phase,
  input  wire logic                            i_sample,
  input  wire logic                            i_flag_clr,
  output logic                                 o_scl_clean,
  output logic                                 o_sda_clean,
  output logic                                 o_scl_hold,
  output logic                                 o_bus_busy,
  output logic                                 o_master,
  output iatf_pkg::iatf_events_t               o_events,
  output logic                                 o_err_event
);

  iatf_pkg::iatf_state_t  state;
  iatf_pkg::iatf_state_t  next_state;
  iatf_pkg::iatf_events_t next_events;
  logic                   scl_d;
  logic                   sda_d;
  logic                   next_busy;
  logic [TOUT_W-1:0]      tcnt;
  logic [TOUT_W-1:0]      next_tcnt;
  logic                   scl_edge;
  logic                   start_cond;
  logic                   stop_cond;
  logic                   mismatch;
  logic                   lost;
  logic                   tout_hit;
  logic                   drive_en;
  logic                   lost_start;
  logic                   lost_tx;
  logic                   lost_busy;
  logic                   lost_nack;
  logic                   lost_slave;

  // ----------------------------------------
  // Line filters
  // ----------------------------------------
  iatf_filter #(
    .STAGES (iatf_pkg::FILT_MAX_STAGES)
  ) u_scl_filt (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_width    (i_filt_width),
    .i_raw      (i_scl_in),
    .o_clean    (o_scl_clean)
  );

  iatf_filter #(
    .STAGES (iatf_pkg::FILT_MAX_STAGES)
  ) u_sda_filt (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_width    (i_filt_width),
    .i_raw      (i_sda_in),
    .o_clean    (o_sda_clean)
  );

  // ----------------------------------------
  // Bus conditions and arbitration checks
  // ----------------------------------------
  always_comb
  begin
    scl_edge   = o_scl_clean ^ scl_d;
    start_cond = o_scl_clean & scl_d & sda_d & ~o_sda_clean;
    stop_cond  = o_scl_clean & scl_d & ~sda_d & o_sda_clean;
    mismatch   = i_drive.sda ^ o_sda_clean;
    drive_en   = ((state == iatf_pkg::IATF_START) | (state == iatf_pkg::IATF_XFER) | i_phase.slave_tx)
               & (state != iatf_pkg::IATF_LOST);
    tout_hit   = i_tout_en && (tcnt == i_tout_limit) && !scl_edge;
  end

  // ----------------------------------------
  // Arbitration loss sources
  // ----------------------------------------
  always_comb
  begin
    lost_start = (state == iatf_pkg::IATF_START) && i_sample && mismatch;
    lost_tx    = (state == iatf_pkg::IATF_XFER) && i_phase.master_tx && i_sample && mismatch;
    lost_busy  = !o_master && i_start_req && o_bus_busy;
    lost_nack  = i_phase.nack_tx && i_sample && ~o_sda_clean;
    lost_slave = i_phase.slave_tx && i_sample && mismatch;
    lost       = lost_start | lost_tx | lost_busy | lost_nack | lost_slave;
  end

  // ----------------------------------------
  // Master state and busy tracking
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_busy  = o_bus_busy;
    if (start_cond)
      next_busy = 1'b1;
    else if (stop_cond)
      next_busy = 1'b0;
    unique case (state)
      iatf_pkg::IATF_IDLE:
        if (i_start_req && !o_bus_busy)
          next_state = iatf_pkg::IATF_START;
      iatf_pkg::IATF_START:
        if (start_cond)
          next_state = iatf_pkg::IATF_XFER;
      iatf_pkg::IATF_XFER:
        if (i_stop_done)
          next_state = iatf_pkg::IATF_IDLE;
      iatf_pkg::IATF_LOST:
        if (stop_cond || !o_bus_busy)
          next_state = iatf_pkg::IATF_IDLE;
    endcase
    if (lost)
      next_state = iatf_pkg::IATF_LOST;
  end

  // ----------------------------------------
  // Timeout counter
  // ----------------------------------------
  always_comb
  begin
    next_tcnt = tcnt;
    if (!i_tout_en || scl_edge)
      next_tcnt = '0;
    else if (tcnt != i_tout_limit)
      next_tcnt = tcnt + TOUT_W'(1);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      tcnt <= '0;
    else
      tcnt <= next_tcnt;
  end

  // ----------------------------------------
  // Sticky event flags, set wins over clear
  // ----------------------------------------
  always_comb
  begin
    next_events = i_flag_clr ? '0 : o_events;
    if (lost)
      next_events.arbitration_lost_detect = 1'b1;
    if (tout_hit)
      next_events.timeout = 1'b1;
    if (start_cond)
      next_events.start_det = 1'b1;
    if (stop_cond)
      next_events.stop_det = 1'b1;
    if (i_drive.sda && i_sample && o_sda_clean && i_phase.master_tx == 1'b0 && state == iatf_pkg::IATF_XFER)
      next_events.nack_det = 1'b1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_events <= '0;
    else
      o_events <= next_events;
  end

  // ----------------------------------------
  // State, busy and line history registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state      <= iatf_pkg::IATF_IDLE;
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      o_bus_busy <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      scl_d      <= o_scl_clean;
      sda_d      <= o_sda_clean;
      o_bus_busy <= next_busy;
    end
  end

  // ----------------------------------------
  // Pin drive and clock synchronisation
  // ----------------------------------------
  always_comb
  begin
    o_master    = (state == iatf_pkg::IATF_START) | (state == iatf_pkg::IATF_XFER);
    o_scl_out   = 1'b0;
    o_sda_out   = 1'b0;
    o_scl_oe    = o_master & ~i_drive.scl;
    o_sda_oe    = drive_en & ~i_drive.sda;
    o_scl_hold  = o_master & i_drive.scl & ~o_scl_clean;
    o_err_event = |o_events;
  end

endmodule

`default_nettype wire

// ---- verification/iatf_bus_model.sv ----
// Model of the other masters and slaves sharing the two lines
`timescale 1ns/1ps
`default_nettype none

module iatf_bus_model (
  input  wire logic i_core_clk,
  output var logic  o_scl_low,
  output var logic  o_sda_low
);
  // ----------------------------------------
  // Open-drain pulls, changed just after an edge
  // ----------------------------------------
  initial {o_scl_low, o_sda_low} = 2'h0;

  task automatic put(input logic scl, input logic sda);
    o_scl_low <= scl;
    o_sda_low <= sda;
  endtask

  // Glitch or stretch on SCL for n cycles
  task automatic pulse(input int n);
    o_scl_low <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    o_scl_low <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- verification/iatf_top_assertions.sv ----
// Checker of arbitration, event and drive outputs
`timescale 1ns/1ps
`default_nettype none

module iatf_top_assertions (
  input wire logic                   i_core_clk,
  input wire logic                   i_sys_rst,
  input wire logic                   i_tout_en,
  input wire logic                   i_start_req,
  input wire iatf_pkg::iatf_lines_t  i_drive,
  input wire iatf_pkg::iatf_phase_t  i_phase,
  input wire logic                   i_sample,
  input wire logic                   i_flag_clr,
  input wire logic                   o_scl_oe,
  input wire logic                   o_sda_clean,
  input wire logic                   o_bus_busy,
  input wire logic                   o_master,
  input wire iatf_pkg::iatf_events_t o_events,
  input wire logic                   o_err_event
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic lost;
  logic mis;
  assign lost = o_events.arbitration_lost_detect;
  assign mis  = i_sample && (o_sda_clean != i_drive.sda);

  property p_scl_oe; o_scl_oe == (o_master && !i_drive.scl); endproperty
  a_scl_oe: assert property (p_scl_oe) else $error("scl drive wrong");
  property p_busy; o_bus_busy && i_start_req && !o_master |=> lost; endproperty
  a_busy: assert property (p_busy) else $error("busy start kept");
  property p_tx; mis && i_phase.master_tx && o_master |=> lost; endproperty
  a_tx: assert property (p_tx) else $error("tx mismatch missed");
  property p_nack; i_sample && i_phase.nack_tx && o_master && !o_sda_clean |=> lost; endproperty
  a_nack: assert property (p_nack) else $error("nack mismatch missed");
  property p_slv; mis && i_phase.slave_tx |=> lost; endproperty
  a_slv: assert property (p_slv) else $error("slave mismatch missed");
  property p_sticky; lost && !i_flag_clr |=> lost; endproperty
  a_sticky: assert property (p_sticky) else $error("loss flag dropped");
  property p_err; o_err_event == (|o_events); endproperty
  a_err: assert property (p_err) else $error("event merge wrong");
  property p_tout; !i_tout_en ##1 !i_tout_en |-> !$rose(o_events.timeout); endproperty
  a_tout: assert property (p_tout) else $error("timeout while off");
  c_lost: cover property ($rose(lost));
  c_tout: cover property ($rose(o_events.timeout));
  c_busy: cover property ($rose(o_bus_busy));
endmodule

bind iatf_top iatf_top_assertions iatf_top_assertions_inst (.i_core_clk, .i_sys_rst, .i_tout_en,
  .i_start_req, .i_drive, .i_phase, .i_sample, .i_flag_clr, .o_scl_oe, .o_sda_clean, .o_bus_busy,
  .o_master, .o_events, .o_err_event);

`default_nettype wire

// ---- verification/i2c_arbitration_timeout_filter_test.sv ----
// Self-checking bench for the arbitration, timeout and filter block
`timescale 1ns/1ps
`default_nettype none

module i2c_arbitration_timeout_filter_test;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_tout_en = 1'b0, i_start_req = 1'b0;
  logic i_stop_done = 1'b0, i_sample = 1'b0, i_flag_clr = 1'b0, mis;
  logic [1:0]             i_filt_width = 2'h1;
  logic [15:0]            i_tout_limit = 16'h0014;
  iatf_pkg::iatf_lines_t  i_drive = 2'h3;
  iatf_pkg::iatf_phase_t  i_phase = 3'h0;
  iatf_pkg::iatf_events_t o_events;
  logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_scl_clean, o_sda_clean;
  logic o_scl_hold, o_bus_busy, o_master, o_err_event, m_scl, m_sda;
  wire logic i_scl_in = !(o_scl_oe || m_scl);
  wire logic i_sda_in = !(o_sda_oe || m_sda);
  int     err_total = 0, n_tests = 0, cyc = 0, w, l;
  integer seed = 32'hd3f081c3;

  iatf_top iatf_top_inst (.i_core_clk, .i_sys_rst, .i_scl_in, .i_sda_in, .o_scl_out, .o_scl_oe,
    .o_sda_out, .o_sda_oe, .i_filt_width, .i_tout_en, .i_tout_limit, .i_start_req, .i_stop_done,
    .i_drive, .i_phase, .i_sample, .i_flag_clr, .o_scl_clean, .o_sda_clean, .o_scl_hold,
    .o_bus_busy, .o_master, .o_events, .o_err_event);
  iatf_bus_model iatf_bus_model_inst (.i_core_clk, .o_scl_low(m_scl), .o_sda_low(m_sda));

  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  initial forever #5 i_core_clk = ~i_core_clk;

  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic bus(input logic scl, input logic sda);
    iatf_bus_model_inst.put(scl, sda);
  endtask

  function automatic logic passes(input int w, input int l);
    return l > w;
  endfunction

  // SCL glitch of l cycles at width w
  task automatic filt(input int w, input int l);
    logic seen;
    seen = 1'b0;
    i_filt_width <= w[1:0];
    cy(8);
    fork
      iatf_bus_model_inst.pulse(l);
      repeat (l + w + 8)
      begin
        @(negedge i_core_clk);
        if (o_scl_clean === 1'b0)
          seen = 1'b1;
      end
    join
    chk(seen, passes(w, l));
  endtask

  // Win the idle bus and issue a start
  task automatic go;
    i_start_req <= 1'b1;
    cy(1);
    i_start_req <= 1'b0;
    i_drive <= 2'h2;
    for (int k = 0; k < 20 && o_bus_busy !== 1'b1; k++)
      cy(1);
    chk(o_events.start_det, 1'b1);
    i_drive <= 2'h0;
    cy(1);
  endtask

  // Stop condition made by the far side, then flags cleared
  task automatic stop;
    i_drive <= 2'h3;
    i_phase <= 3'h0;
    bus(1'b1, 1'b0);
    cy(8);
    bus(1'b1, 1'b1);
    cy(8);
    bus(1'b0, 1'b1);
    cy(8);
    bus(1'b0, 1'b0);
    i_stop_done <= 1'b1;
    cy(1);
    i_stop_done <= 1'b0;
    cy(12);
    chk(o_events.stop_det, 1'b1);
    chk(o_bus_busy, 1'b0);
    i_flag_clr <= 1'b1;
    cy(1);
    i_flag_clr <= 1'b0;
    cy(1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    cy(4);
    i_sys_rst <= 1'b0;
    cy(2);
    chk(o_err_event, 1'b0);
    chk(o_sda_oe, 1'b0);
    chk(o_scl_out, 1'b0);
    chk(o_sda_out, 1'b0);
    for (int k = 0; k < 12; k++)
    begin
      w = k % 4;
      l = 1 + {$random(seed)} % 6;
      if (l == w + 1 && w != 0)
        l++;
      filt(w, l);
    end
    i_filt_width <= 2'h1;
    for (int k = 0; k < 6; k++)
    begin
      mis = $random(seed);
      go();
      i_phase <= 3'h4 >> (k % 3);
      i_drive <= 2'h1;
      bus(1'b0, mis);
      cy(2);
      i_drive <= 2'h3;
      bus(1'b1, mis);
      cy(10);
      chk(o_scl_hold, 1'b1);
      chk(o_scl_oe, 1'b0);
      bus(1'b0, mis);
      cy(10);
      chk(o_sda_clean, ~mis);
      i_sample <= 1'b1;
      cy(1);
      i_sample <= 1'b0;
      cy(2);
      chk(o_events.arbitration_lost_detect, mis);
      chk(o_master, ~mis);
      chk(o_events.nack_det, !mis && (k % 3 != 0));
      i_drive <= 2'h0;
      cy(1);
      chk(o_sda_oe, ~mis);
      chk(o_scl_oe, ~mis);
      stop();
    end
    bus(1'b0, 1'b1);
    cy(12);
    chk(o_bus_busy, 1'b1);
    i_start_req <= 1'b1;
    cy(1);
    i_start_req <= 1'b0;
    cy(2);
    chk(o_events.arbitration_lost_detect, 1'b1);
    chk(o_master, 1'b0);
    stop();
    i_start_req <= 1'b1;
    cy(1);
    i_start_req <= 1'b0;
    bus(1'b0, 1'b1);
    cy(4);
    i_sample <= 1'b1;
    cy(2);
    i_sample <= 1'b0;
    cy(2);
    chk(o_events.arbitration_lost_detect, 1'b1);
    chk(o_master, 1'b0);
    stop();
    bus(1'b1, 1'b0);
    cy(60);
    chk(o_events.timeout, 1'b0);
    i_tout_en <= 1'b1;
    cy(15);
    chk(o_events.timeout, 1'b0);
    bus(1'b0, 1'b0);
    cy(4);
    bus(1'b1, 1'b0);
    cy(15);
    chk(o_events.timeout, 1'b0);
    cy(20);
    chk(o_events.timeout, 1'b1);
    chk(o_err_event, 1'b1);
    stop_test();
  end
endmodule

`default_nettype wire
